//--- sim/mcc_config_regs_test.sv
// mcc_config_regs_test: self-checking bench for the converter config registers
// assumes one 10 MHz clock, strap pins held fixed across reset
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
	$display("[FAIL] %s expected %h seen %h", n, e, g); end end
module mcc_config_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock = 1'b0;
	logic        srst = 1'b1;
	logic [4:0]  addr = 5'h00;
	logic [15:0] wr_data = 16'h0000;
	logic        wr_stb = 1'b0;
	logic        rd_stb = 1'b0;
	logic        pll_filter_reset = 1'b0;
	logic        fiber_freq_raw = 1'b0;
	logic        copper_freq_raw = 1'b0;
	logic        standby_path_pin = 1'b1;
	logic [15:0] rd_data;
	logic [10:0] scr_state;
	logic        r10, r100, fdm, lwl, sfr, rcd, cdm, scr, son, spr, set, fso, rfo, spe, ffa, cfa;
	int          bad_count = 0;
	int          compares = 0;
	always #50 clock = ~clock;
	// straps: speed on, fiber pecl off, copper pecl on
	mcc_config_regs dut_u (.clock(clock), .srst(srst), .addr(addr), .wr_data(wr_data),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .strap_speed(1'b1),
		.strap_fiber_pecl(1'b0), .strap_copper_pecl(1'b1), .standby_path_pin(standby_path_pin),
		.pll_filter_reset(pll_filter_reset), .fiber_freq_raw(fiber_freq_raw),
		.copper_freq_raw(copper_freq_raw), .rate_10_allowed(r10), .rate_100_allowed(r100),
		.fiber_diff_io_mode(fdm), .long_wavelength(lwl), .short_fiber_reach(sfr),
		.reduced_copper_drive(rcd), .copper_diff_io_mode(cdm), .short_copper_reach(scr),
		.scrambling_on(son), .scrambler_preset(spr), .scr_state(scr_state),
		.soft_edge_ternary(set), .freq_sense_off(fso), .remote_fault_off(rfo),
		.standby_path_en(spe), .fiber_freq_alarm(ffa), .copper_freq_alarm(cfa));
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clock);
		addr <= a;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge clock);
		wr_stb <= 1'b0;
	endtask
	// data stands only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [4:0] a, output logic [15:0] v);
		@(posedge clock);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1 v = rd_data;
	endtask
	task automatic settle;
		repeat (2) @(posedge clock);
		#1;
	endtask
	task automatic t_reset_vals;
		logic [15:0] v;
		rd(mcc_pkg::AUX_OFFSET, v);
		`CHK("aux_reset", mcc_pkg::AUX_RESET, v)
		rd(mcc_pkg::CFG_OFFSET, v);
		`CHK("cfg_reset", 16'h031E, v)
		`CHK("rates_reset", 2'b10, {r10, r100})
		`CHK("cu_reset", 3'b100, {cdm, rcd, scr})
		`CHK("scr_on_reset", 1'b1, son)
	endtask
	task automatic t_aux;
		logic [15:0] v;
		@(posedge clock);
		fiber_freq_raw <= 1'b1;
		copper_freq_raw <= 1'b1;
		wr(mcc_pkg::AUX_OFFSET, 16'hFFFF);
		rd(mcc_pkg::AUX_OFFSET, v);
		`CHK("aux_ones", 16'hFFFF, v)
		`CHK("aux_on", 4'b1110, {set, fso, rfo, spe})
		`CHK("alarm_gated", 2'b00, {ffa, cfa})
		wr(mcc_pkg::AUX_OFFSET, 16'h0000);
		rd(mcc_pkg::AUX_OFFSET, v);
		`CHK("aux_zero", 16'h0000, v)
		`CHK("aux_off", 4'b0001, {set, fso, rfo, spe})
		`CHK("alarm_pass", 2'b11, {ffa, cfa})
		@(posedge clock);
		standby_path_pin <= 1'b0;
		settle;
		`CHK("standby_pin_low", 1'b0, spe)
		@(posedge clock);
		standby_path_pin <= 1'b1;
		@(posedge clock);
		pll_filter_reset <= 1'b1;
		settle;
		`CHK("alarm_pll", 2'b00, {ffa, cfa})
		@(posedge clock);
		pll_filter_reset <= 1'b0;
		fiber_freq_raw <= 1'b0;
		copper_freq_raw <= 1'b0;
		rd(5'h1D, v);
		`CHK("unmapped", 16'h0000, v)
	endtask
	// upper six bits written as ones must not stick in the config register
	task automatic t_rate;
		logic [15:0] w [3] = '{16'hFC00, 16'hFF00, 16'hFE00};
		logic [1:0]  e [3] = '{2'b11, 2'b10, 2'b01};
		logic [15:0] v;
		for (int i = 0; i < 3; i++)
		begin
			wr(mcc_pkg::CFG_OFFSET, w[i]);
			rd(mcc_pkg::CFG_OFFSET, v);
			`CHK("cfg_back", w[i] & 16'h03FF, v)
			`CHK("rates", e[i], {r10, r100})
		end
	endtask
	task automatic pk(input logic [15:0] w, input logic [5:0] e);
		wr(mcc_pkg::CFG_OFFSET, w);
		settle;
		`CHK("media", e, {fdm, lwl, sfr, rcd, cdm, scr})
	endtask
	task automatic t_scr;
		logic [10:0] s;
		wr(mcc_pkg::CFG_OFFSET, 16'h0003);
		settle;
		`CHK("preset", {1'b1, mcc_pkg::SCR_SEED}, {spr, scr_state})
		wr(mcc_pkg::CFG_OFFSET, 16'h0002);
		repeat (6) @(posedge clock);
		#1;
		`CHK("scr_runs", 1'b1, scr_state !== 11'h003)
		wr(mcc_pkg::CFG_OFFSET, 16'h0000);
		settle;
		s = scr_state;
		repeat (3) @(posedge clock);
		#1;
		`CHK("scr_holds", s, scr_state)
		wr(mcc_pkg::CFG_OFFSET, 16'h0001);
		settle;
		`CHK("scr_reseed", 11'h003, scr_state)
	endtask
	// mid-run reset must reload the straps over whatever software wrote
	task automatic t_rereset;
		logic [15:0] v;
		wr(mcc_pkg::AUX_OFFSET, 16'hFFFF);
		wr(mcc_pkg::CFG_OFFSET, 16'h0000);
		@(posedge clock);
		srst <= 1'b1;
		repeat (6) @(posedge clock);
		#1;
		`CHK("outs_in_reset", 3'b000, {r10, son, fso})
		@(posedge clock);
		srst <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
		rd(mcc_pkg::CFG_OFFSET, v);
		`CHK("cfg_reload", 16'h031E, v)
		rd(mcc_pkg::AUX_OFFSET, v);
		`CHK("aux_reload", mcc_pkg::AUX_RESET, v)
		`CHK("rates_reload", 2'b10, {r10, r100})
	endtask
	// write then read with no idle cycle between the strobes
	task automatic t_b2b;
		logic [15:0] v;
		@(posedge clock);
		addr <= mcc_pkg::AUX_OFFSET;
		wr_data <= 16'hA5A0;
		wr_stb <= 1'b1;
		@(posedge clock);
		wr_stb <= 1'b0;
		rd_stb <= 1'b1;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1 v = rd_data;
		`CHK("b2b_read", 16'hA5A0, v)
	endtask
	task automatic conclude;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// cut a hang short; the run itself needs well under this
	initial
	begin
		repeat (4000) @(posedge clock);
		bad_count++;
		conclude;
	end
	initial
	begin
		repeat (6) @(posedge clock);
		srst <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
		t_reset_vals;
		t_aux;
		t_rate;
		pk(16'h00F4, 6'b100101);
		pk(16'h007C, 6'b001010);
		pk(16'h0040, 6'b010000);
		t_scr;
		t_rereset;
		t_b2b;
		conclude;
	end
endmodule

//--- verilog/mcc_bit_reg.sv
// mcc_bit_reg: one 16-bit software register with a load-at-reset value
// assumes reset value is a stable constant or a strap caught while srst is high
module mcc_bit_reg (
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic [15:0] reset_val,
	input  wire logic        wr_en,
	input  wire logic [15:0] wr_data,
	output logic      [15:0] value_q
);
	logic [15:0] value_d;

	always_comb
	begin
		value_d = value_q;
		if (wr_en)
			value_d = wr_data;
	end

	// synchronous reset loads the straps, so no async-constant hazard
	always_ff @(posedge clock)
	begin
		if (srst)
			value_q <= reset_val;
		else
			value_q <= value_d;
	end
endmodule

//--- verilog/mcc_config_regs.sv
// mcc_config_regs: interface configuration (low half) and auxiliary line control
// assumes strap pins stable around reset, strobes one cycle, never both at once
module mcc_config_regs (
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic [4:0]  addr,
	input  wire logic [15:0] wr_data,
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	output logic      [15:0] rd_data,
	input  wire logic        strap_speed,
	input  wire logic        strap_fiber_pecl,
	input  wire logic        strap_copper_pecl,
	input  wire logic        standby_path_pin,
	input  wire logic        pll_filter_reset,
	input  wire logic        fiber_freq_raw,
	input  wire logic        copper_freq_raw,
	output logic             rate_10_allowed,
	output logic             rate_100_allowed,
	output logic             fiber_diff_io_mode,
	output logic             long_wavelength,
	output logic             short_fiber_reach,
	output logic             reduced_copper_drive,
	output logic             copper_diff_io_mode,
	output logic             short_copper_reach,
	output logic             scrambling_on,
	output logic             scrambler_preset,
	output logic [10:0]      scr_state,
	output logic             soft_edge_ternary,
	output logic             freq_sense_off,
	output logic             remote_fault_off,
	output logic             standby_path_en,
	output logic             fiber_freq_alarm,
	output logic             copper_freq_alarm
);
	logic [15:0] cfg_q;
	logic [15:0] aux_q;
	logic [15:0] cfg_rst;
	logic [15:0] rd_data_d;
	logic [10:0] scr_d;
	logic [15:0] outs_d;
	logic        live_d;
	logic        live_q;

	// speed strap gives dual rate (0) or forced 10 (1); 100-only must be written
	always_comb
	begin
		cfg_rst = 16'h0000;
		cfg_rst[mcc_pkg::SINGLE_BIT]     = strap_speed;
		cfg_rst[mcc_pkg::PICK_LOW_BIT]   = strap_speed;
		cfg_rst[mcc_pkg::FIBER_DIF_BIT]  = strap_fiber_pecl;
		cfg_rst[mcc_pkg::LONG_WL_BIT]    = strap_fiber_pecl;
		cfg_rst[mcc_pkg::SHORT_FO_BIT]   = strap_fiber_pecl;
		cfg_rst[mcc_pkg::REDUCED_BIT]    = strap_copper_pecl;
		cfg_rst[mcc_pkg::COPPER_DIF_BIT] = strap_copper_pecl;
		cfg_rst[mcc_pkg::SHORT_TP_BIT]   = strap_copper_pecl;
		cfg_rst[mcc_pkg::SCR_ON_BIT]     = strap_copper_pecl;
	end

	// only the low half lives here; upper bits belong to another block
	mcc_bit_reg u_cfg (
		.clock     (clock),
		.srst      (srst),
		.reset_val (cfg_rst),
		.wr_en     (wr_stb && addr == mcc_pkg::CFG_OFFSET),
		.wr_data   ({6'h00, wr_data[9:0] & mcc_pkg::LOW_HALF_MASK}),
		.value_q   (cfg_q)
	);

	mcc_bit_reg u_aux (
		.clock     (clock),
		.srst      (srst),
		.reset_val (mcc_pkg::AUX_RESET),
		.wr_en     (wr_stb && addr == mcc_pkg::AUX_OFFSET),
		.wr_data   (wr_data),
		.value_q   (aux_q)
	);

	always_comb
	begin
		rd_data_d = 16'h0000;
		if (rd_stb)
		begin
			if (addr == mcc_pkg::CFG_OFFSET)
				rd_data_d = cfg_q;
			else if (addr == mcc_pkg::AUX_OFFSET)
				rd_data_d = aux_q;
		end
	end

	// scrambler state: held at seed while preset, LFSR steps while scrambling on, holds otherwise
	always_comb
	begin
		scr_d = scr_state;
		if (cfg_q[mcc_pkg::SCR_PRESET_BIT])
			scr_d = mcc_pkg::SCR_SEED;
		else if (cfg_q[mcc_pkg::SCR_ON_BIT])
			scr_d = {scr_state[9:0], scr_state[10] ^ scr_state[8]};
	end

	always_comb
	begin
		outs_d = 16'h0000;
		// outputs still show reset zeros one edge after release
		live_d = 1'b1;
		// both rates allowed unless single-rate is set
		outs_d[0] = !cfg_q[mcc_pkg::SINGLE_BIT] || cfg_q[mcc_pkg::PICK_LOW_BIT];
		outs_d[1] = !cfg_q[mcc_pkg::SINGLE_BIT] || !cfg_q[mcc_pkg::PICK_LOW_BIT];
		outs_d[2] = cfg_q[mcc_pkg::FIBER_DIF_BIT];
		// quantizer unused in PECL or short reach, so wavelength is moot
		outs_d[3] = cfg_q[mcc_pkg::LONG_WL_BIT] && !cfg_q[mcc_pkg::FIBER_DIF_BIT]
			&& !cfg_q[mcc_pkg::SHORT_FO_BIT];
		outs_d[4] = cfg_q[mcc_pkg::SHORT_FO_BIT] && !cfg_q[mcc_pkg::FIBER_DIF_BIT];
		outs_d[5] = cfg_q[mcc_pkg::REDUCED_BIT] && !cfg_q[mcc_pkg::COPPER_DIF_BIT];
		outs_d[6] = cfg_q[mcc_pkg::COPPER_DIF_BIT];
		outs_d[7] = cfg_q[mcc_pkg::SHORT_TP_BIT] && !cfg_q[mcc_pkg::COPPER_DIF_BIT];
		outs_d[8] = cfg_q[mcc_pkg::SCR_ON_BIT];
		outs_d[9] = cfg_q[mcc_pkg::SCR_PRESET_BIT];
		outs_d[10] = aux_q[mcc_pkg::SOFT_EDGE_BIT];
		outs_d[11] = aux_q[mcc_pkg::FSENSE_OFF_BIT];
		outs_d[12] = aux_q[mcc_pkg::FAULT_OFF_BIT];
		outs_d[13] = standby_path_pin && !aux_q[mcc_pkg::STANDBY_OFF_BIT];
		outs_d[14] = fiber_freq_raw && !aux_q[mcc_pkg::FSENSE_OFF_BIT]
			&& !pll_filter_reset;
		outs_d[15] = copper_freq_raw && !aux_q[mcc_pkg::FSENSE_OFF_BIT]
			&& !pll_filter_reset;
	end

	// outputs lag the register by one cycle so each leaves a flip-flop
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			rd_data              <= 16'h0000;
			scr_state            <= mcc_pkg::SCR_SEED;
			rate_10_allowed      <= 1'b0;
			rate_100_allowed     <= 1'b0;
			fiber_diff_io_mode   <= 1'b0;
			long_wavelength      <= 1'b0;
			short_fiber_reach    <= 1'b0;
			reduced_copper_drive <= 1'b0;
			copper_diff_io_mode  <= 1'b0;
			short_copper_reach   <= 1'b0;
			scrambling_on        <= 1'b0;
			scrambler_preset     <= 1'b0;
			soft_edge_ternary    <= 1'b0;
			freq_sense_off       <= 1'b0;
			remote_fault_off     <= 1'b0;
			standby_path_en      <= 1'b0;
			fiber_freq_alarm     <= 1'b0;
			copper_freq_alarm    <= 1'b0;
			live_q               <= 1'b0;
		end
		else
		begin
			rd_data              <= rd_data_d;
			scr_state            <= scr_d;
			rate_10_allowed      <= outs_d[0];
			rate_100_allowed     <= outs_d[1];
			fiber_diff_io_mode   <= outs_d[2];
			long_wavelength      <= outs_d[3];
			short_fiber_reach    <= outs_d[4];
			reduced_copper_drive <= outs_d[5];
			copper_diff_io_mode  <= outs_d[6];
			short_copper_reach   <= outs_d[7];
			scrambling_on        <= outs_d[8];
			scrambler_preset     <= outs_d[9];
			soft_edge_ternary    <= outs_d[10];
			freq_sense_off       <= outs_d[11];
			remote_fault_off     <= outs_d[12];
			standby_path_en      <= outs_d[13];
			fiber_freq_alarm     <= outs_d[14];
			copper_freq_alarm    <= outs_d[15];
			live_q               <= live_d;
		end
	end

	// positive checks on the one-bit outputs wait for live_q: the first edge after release still shows zeros
	single_rate_a: assert property (@(posedge clock) disable iff (srst)
		cfg_q[mcc_pkg::SINGLE_BIT]
		|=> !(rate_10_allowed && rate_100_allowed))
		else $error("both rates allowed in single-rate mode");
	dual_rate_a: assert property (@(posedge clock) disable iff (srst)
		live_q && !cfg_q[mcc_pkg::SINGLE_BIT]
		|=> rate_10_allowed && rate_100_allowed)
		else $error("a rate barred with single-rate off");
	pick_rate_a: assert property (@(posedge clock) disable iff (srst)
		live_q && cfg_q[mcc_pkg::SINGLE_BIT] && cfg_q[mcc_pkg::PICK_LOW_BIT]
		|=> rate_10_allowed && !rate_100_allowed)
		else $error("low rate pick not honoured");
	pick_high_a: assert property (@(posedge clock) disable iff (srst)
		live_q && cfg_q[mcc_pkg::SINGLE_BIT] && !cfg_q[mcc_pkg::PICK_LOW_BIT]
		|=> !rate_10_allowed && rate_100_allowed)
		else $error("high rate pick not honoured");

	// fiber side
	fiber_mode_a: assert property (@(posedge clock) disable iff (srst)
		live_q
		|=> fiber_diff_io_mode == $past(cfg_q[mcc_pkg::FIBER_DIF_BIT]))
		else $error("fiber interface mode does not follow its bit");
	wavelength_a: assert property (@(posedge clock) disable iff (srst)
		live_q && !cfg_q[mcc_pkg::FIBER_DIF_BIT] && !cfg_q[mcc_pkg::SHORT_FO_BIT]
		|=> long_wavelength == $past(cfg_q[mcc_pkg::LONG_WL_BIT]))
		else $error("wavelength pick not honoured");
	fiber_reach_a: assert property (@(posedge clock) disable iff (srst)
		cfg_q[mcc_pkg::FIBER_DIF_BIT]
		|=> !short_fiber_reach && !long_wavelength)
		else $error("fiber reach active in PECL mode");
	fiber_short_a: assert property (@(posedge clock) disable iff (srst)
		live_q && !cfg_q[mcc_pkg::FIBER_DIF_BIT]
		|=> short_fiber_reach == $past(cfg_q[mcc_pkg::SHORT_FO_BIT]))
		else $error("fiber reach pick not honoured");

	// copper side
	copper_pecl_a: assert property (@(posedge clock) disable iff (srst)
		cfg_q[mcc_pkg::COPPER_DIF_BIT]
		|=> !reduced_copper_drive && !short_copper_reach)
		else $error("copper options active in PECL mode");
	copper_drive_a: assert property (@(posedge clock) disable iff (srst)
		live_q && !cfg_q[mcc_pkg::COPPER_DIF_BIT]
		|=> reduced_copper_drive == $past(cfg_q[mcc_pkg::REDUCED_BIT]))
		else $error("copper drive level not honoured");
	copper_mode_a: assert property (@(posedge clock) disable iff (srst)
		live_q
		|=> copper_diff_io_mode == $past(cfg_q[mcc_pkg::COPPER_DIF_BIT]))
		else $error("copper interface mode does not follow its bit");
	eq_bypass_a: assert property (@(posedge clock) disable iff (srst)
		live_q && !cfg_q[mcc_pkg::COPPER_DIF_BIT]
		|=> short_copper_reach == $past(cfg_q[mcc_pkg::SHORT_TP_BIT]))
		else $error("equalizer bypass not honoured");

	// scrambler
	scramble_en_a: assert property (@(posedge clock) disable iff (srst)
		live_q
		|=> scrambling_on == $past(cfg_q[mcc_pkg::SCR_ON_BIT]))
		else $error("scrambler enable does not follow its bit");
	scr_idle_a: assert property (@(posedge clock) disable iff (srst)
		!cfg_q[mcc_pkg::SCR_ON_BIT] && !cfg_q[mcc_pkg::SCR_PRESET_BIT]
		|=> $stable(scr_state))
		else $error("scrambler moved while disabled");
	scr_hold_a: assert property (@(posedge clock) disable iff (srst)
		cfg_q[mcc_pkg::SCR_PRESET_BIT]
		|=> scr_state == mcc_pkg::SCR_SEED)
		else $error("scrambler not held at seed");
	preset_flag_a: assert property (@(posedge clock) disable iff (srst)
		live_q
		|=> scrambler_preset == $past(cfg_q[mcc_pkg::SCR_PRESET_BIT]))
		else $error("preset flag does not follow its bit");

	// auxiliary controls and read data
	soft_edge_a: assert property (@(posedge clock) disable iff (srst)
		live_q
		|=> soft_edge_ternary == $past(aux_q[mcc_pkg::SOFT_EDGE_BIT]))
		else $error("edge softening does not follow its bit");
	fsense_off_a: assert property (@(posedge clock) disable iff (srst)
		live_q
		|=> freq_sense_off == $past(aux_q[mcc_pkg::FSENSE_OFF_BIT]))
		else $error("frequency sensing control does not follow its bit");
	fault_off_a: assert property (@(posedge clock) disable iff (srst)
		live_q
		|=> remote_fault_off == $past(aux_q[mcc_pkg::FAULT_OFF_BIT]))
		else $error("far-end-fault control does not follow its bit");
	standby_off_a: assert property (@(posedge clock) disable iff (srst)
		aux_q[mcc_pkg::STANDBY_OFF_BIT]
		|=> !standby_path_en)
		else $error("standby path not overridden");
	standby_pass_a: assert property (@(posedge clock) disable iff (srst)
		live_q && !aux_q[mcc_pkg::STANDBY_OFF_BIT]
		|=> standby_path_en == $past(standby_path_pin))
		else $error("standby pin not passed through");
	aux_write_a: assert property (@(posedge clock) disable iff (srst)
		(wr_stb && addr == mcc_pkg::AUX_OFFSET) ##1 (rd_stb && addr == mcc_pkg::AUX_OFFSET)
		|=> rd_data == $past(wr_data, 2))
		else $error("aux register readback mismatch");
	read_idle_a: assert property (@(posedge clock) disable iff (srst)
		!rd_stb
		|=> rd_data == 16'h0000)
		else $error("read data left standing without a read");

	// no disable here: these two watch the reset itself, mid-run ones included
	aux_reset_a: assert property (@(posedge clock)
		srst
		|=> aux_q == mcc_pkg::AUX_RESET)
		else $error("aux register not cleared by reset");
	strap_load_a: assert property (@(posedge clock)
		srst
		|=> cfg_q[mcc_pkg::SINGLE_BIT] == $past(strap_speed)
			&& cfg_q[mcc_pkg::PICK_LOW_BIT] == $past(strap_speed)
			&& cfg_q[mcc_pkg::FIBER_DIF_BIT] == $past(strap_fiber_pecl)
			&& cfg_q[mcc_pkg::COPPER_DIF_BIT] == $past(strap_copper_pecl)
			&& !cfg_q[mcc_pkg::SCR_PRESET_BIT])
		else $error("config defaults not loaded from straps");

	// alarms
	freq_alarm_a: assert property (@(posedge clock) disable iff (srst)
		aux_q[mcc_pkg::FSENSE_OFF_BIT] || pll_filter_reset
		|=> !fiber_freq_alarm && !copper_freq_alarm)
		else $error("frequency alarm while sensing off");
	alarm_pass_a: assert property (@(posedge clock) disable iff (srst)
		live_q && !aux_q[mcc_pkg::FSENSE_OFF_BIT] && !pll_filter_reset
		|=> fiber_freq_alarm == $past(fiber_freq_raw)
			&& copper_freq_alarm == $past(copper_freq_raw))
		else $error("frequency alarm not passed while sensing on");
endmodule

//--- verilog/mcc_pkg.sv
// mcc_pkg: offsets, bit positions and reset values for the converter config regs
// assumes a 5-bit register index on the management port, 16-bit data
package mcc_pkg;
	localparam logic [4:0]  AUX_OFFSET    = 5'h1C;
	localparam logic [4:0]  CFG_OFFSET    = 5'h1E;
	localparam logic [15:0] AUX_RESET     = 16'h0000;
	localparam int          SINGLE_BIT    = 9;
	localparam int          PICK_LOW_BIT  = 8;
	localparam int          FIBER_DIF_BIT = 7;
	localparam int          LONG_WL_BIT   = 6;
	localparam int          SHORT_FO_BIT  = 5;
	localparam int          REDUCED_BIT   = 4;
	localparam int          COPPER_DIF_BIT = 3;
	localparam int          SHORT_TP_BIT  = 2;
	localparam int          SCR_ON_BIT    = 1;
	localparam int          SCR_PRESET_BIT = 0;
	localparam int          SOFT_EDGE_BIT = 4;
	localparam int          FSENSE_OFF_BIT = 3;
	localparam int          FAULT_OFF_BIT = 2;
	localparam int          STANDBY_OFF_BIT = 1;
	localparam logic [10:0] SCR_SEED      = 11'h003;
	localparam logic [9:0]  LOW_HALF_MASK = 10'h3FF;
endpackage
